// [els_pkg.sv]
package els_pkg;
    // lane count of the processor and 64-bit pci data paths
    localparam int LANES = 8;

    // register byte offsets on the apb side
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_IMG_END = 8'h04;
    localparam logic [7:0] OFS_DMA_END = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_DMA_CUR = 8'h14;

    // writable configuration words and their indices
    localparam int         CFG_WORDS = 4;
    localparam logic [1:0] CFG_CTRL  = 2'h0;
    localparam logic [1:0] CFG_IMG   = 2'h1;
    localparam logic [1:0] CFG_DMA   = 2'h2;
    localparam logic [1:0] CFG_MASK  = 2'h3;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam int         CTRL_END_BIT = 0;

    // register word indices seen from the processor port
    localparam logic [3:0] WORD_PCI0 = 4'h6;
    localparam logic [3:0] WORD_LAST = 4'h8;

    // processor address munge values per scalar size
    localparam logic [2:0] MUNGE_WORD = 3'h4;
    localparam logic [2:0] MUNGE_HALF = 3'h6;
    localparam logic [2:0] MUNGE_BYTE = 3'h7;
    localparam logic [2:0] MUNGE_NONE = 3'h0;

    // transfer sizes in bytes
    localparam logic [3:0] SIZE_NONE = 4'h0;
    localparam logic [3:0] SIZE_BYTE = 4'h1;
    localparam logic [3:0] SIZE_HALF = 4'h2;
    localparam logic [3:0] SIZE_WORD = 4'h4;

    // interrupt status bit positions
    localparam int IRQ_W   = 3;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_PCI = 1;
    localparam int IRQ_DMA = 2;

    // two-bit endian field encodings
    typedef enum logic [1:0] {
        END_BIG         = 2'h0,
        END_MUNGED      = 2'h1,
        END_LITTLE      = 2'h2,
        END_TRUE_LITTLE = 2'h3
    } els_end_type;

    // origin of a generated pci transaction
    typedef enum logic [1:0] {
        SRC_IMAGE = 2'h0,
        SRC_CONF  = 2'h1,
        SRC_IACK1 = 2'h2,
        SRC_IACK2 = 2'h3
    } els_src_type;

    typedef struct packed {
        logic        we;
        logic        to_pci;
        logic [2:0]  img;
        logic [2:0]  dword;
        logic [2:0]  addr;
        logic [3:0]  size;
        logic [63:0] data;
    } els_proc_req_type;

    typedef struct packed {
        els_src_type src;
        logic [2:0]  addr_low;
        logic [7:0]  be;
        logic [63:0] data;
    } els_pci_req_type;

    // xor value that the processor applies to the low address bits
    function automatic logic [2:0] els_munge(input logic [3:0] size);
        case (size)
            SIZE_WORD: els_munge = MUNGE_WORD;
            SIZE_HALF: els_munge = MUNGE_HALF;
            SIZE_BYTE: els_munge = MUNGE_BYTE;
            default:   els_munge = MUNGE_NONE;
        endcase
    endfunction : els_munge
endpackage : els_pkg

// [els_reg_steer.sv]
`timescale 1ns/1ps
module els_reg_steer
    import els_pkg::*;
(
    input  wire logic                  munged,
    input  wire logic [2:0]            addr,
    input  wire logic [3:0]            size,
    output logic      [LANES-1:0]      lane_en,
    output logic      [LANES-1:0][2:0] reg_byte,
    output logic                       bad
);
    wire [2:0] mg   = els_munge(size);
    wire [3:0] span = {1'b0, addr} + size;
    wire [3:0] half = {2'h0, addr[1:0]} + size;

    // per lane: enable and little-endian register byte it reaches
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        wire [2:0] n = 3'(i);
        wire [2:0] m = munged ? n ^ mg : n;
        assign lane_en[i]  = (n >= addr) && ({1'b0, n} < span);
        assign reg_byte[i] = {m[2], ~m[1:0]};
    end

    // big-endian: up to a word inside one half; munged: aligned 1/2/4
    wire be_bad = (size == SIZE_NONE) || (size > SIZE_WORD)
                  || (half > SIZE_WORD);
    wire ml_bad = !((size == SIZE_BYTE) || (size == SIZE_HALF)
                  || (size == SIZE_WORD))
                  || (({1'b0, addr} & (size - SIZE_BYTE)) != 4'h0);
    assign bad = munged ? ml_bad : be_bad;
endmodule : els_reg_steer

// [els_pci_steer.sv]
`timescale 1ns/1ps
module els_pci_steer
    import els_pkg::*;
(
    input  wire els_end_type       mode,
    input  wire logic [63:0]       proc_data,
    input  wire logic [LANES-1:0]  lane_en,
    input  wire logic [2:0]        addr,
    input  wire logic [3:0]        size,
    output logic      [63:0]       pci_data,
    output logic      [LANES-1:0]  pci_be,
    output logic      [2:0]        pci_addr_low
);
    // each pci lane picks its processor source lane
    for (genvar p = 0; p < LANES; p++) begin : g_lane
        wire [2:0] pl  = 3'(p);
        wire [2:0] src = (mode == END_BIG)         ? pl :
                         (mode == END_TRUE_LITTLE) ? {pl[2], ~pl[1:0]}
                                                   : ~pl;
        // processor lane n sits at big-endian bits 8n..8n+7
        assign pci_data[8*p +: 8] = proc_data[{~src, 3'h0} +: 8];
        assign pci_be[p]          = lane_en[src];
    end

    // munged traffic has its address munge undone
    assign pci_addr_low = (mode == END_MUNGED) ? addr ^ els_munge(size)
                                               : addr;
endmodule : els_pci_steer

// [els_endian_lane_steering.sv]
`timescale 1ns/1ps
// Functional notes
// - pci-to-pci traffic passes with no swap or conversion at all.
// - pci address bits 2:0 pick byte lane n on bits 8n+7..8n.
// - processor address bits 29:31 pick lane n; lane 0 is msb byte.
// - register endian mode bit lives in control word; resets big-endian.
// - registers are little-endian; processor accesses keep scalar significance.
// - big-endian register mode maps lanes 0..3 to bytes 3..0 per half.
// - munged register mode undoes munge; only byte, half, word sizes.
// - munged register mode answers unaligned access with transfer error.
// - config data and iack registers generate pci transfers, pci mapping.
// - four pci conversion modes: big, little, munged little, true little.
// - two-bit endian field per image and per dma channel.
// - dma channel takes new endian mode per transfer or list element.
// - big-endian pci mode keeps each byte's address, lane n to n.
module els_endian_lane_steering
    import els_pkg::*;
#(
    parameter int NUM_IMG = 8,
    parameter int NUM_DMA = 4
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    input  wire logic                   proc_req,
    input  wire els_proc_req_type       proc_req_data,
    output logic                        proc_ack,
    output logic                        proc_transfer_error_ack,
    output logic      [63:0]            proc_rdata,
    output logic                        pci_req,
    output els_pci_req_type             pci_out,
    input  wire logic                   pci_fwd_valid_in,
    input  wire logic [63:0]            pci_fwd_in,
    output logic                        pci_fwd_valid,
    output logic      [63:0]            pci_fwd_out,
    input  wire logic [NUM_DMA-1:0]     dma_load,
    input  wire logic [NUM_DMA-1:0]     dma_from_list,
    input  wire logic [2*NUM_DMA-1:0]   dma_elem_end,
    output logic      [2*NUM_DMA-1:0]   dma_cur,
    output logic      [2*NUM_IMG-1:0]   img_end
);
    logic [31:0]            cfg [CFG_WORDS];
    logic [31:0]            next_cfg [CFG_WORDS];
    logic [31:0]            rd_words [8];
    logic [IRQ_W-1:0]       status;
    logic [IRQ_W-1:0]       next_status;
    logic [IRQ_W-1:0]       irq_event;
    logic [IRQ_W-1:0]       w1c;
    logic [LANES-1:0]       lane_en;
    logic [LANES-1:0][2:0]  reg_byte;
    logic                   steer_bad;
    logic [63:0]            next_rdata;
    logic [63:0]            pci_data;
    logic [7:0]             pci_be;
    logic [2:0]             pci_addr_low;
    els_end_type            pci_mode;
    els_src_type            pci_src;
    wire  [2*NUM_DMA-1:0]   next_dma;
    els_proc_req_type       preq;

    assign preq = proc_req_data;

    // apb decode, zero wait states
    wire apb_setup   = psel & ~penable;
    wire apb_access  = psel & penable;
    wire apb_write   = apb_access & pwrite;
    wire hit_cfg     = (paddr <= OFS_MASK) && (paddr[1:0] == 2'h0);
    wire hit_status  = paddr == OFS_STATUS;
    wire hit_dma_cur = paddr == OFS_DMA_CUR;
    wire apb_mapped  = hit_cfg | hit_status | hit_dma_cur;
    wire [31:0] apb_rd_word = hit_cfg     ? cfg[paddr[3:2]] :
                              hit_status  ? 32'(status)     :
                              hit_dma_cur ? 32'(dma_cur)    : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~apb_mapped;

    // register endian mode and processor lane mapping
    wire reg_munged = cfg[CFG_CTRL][CTRL_END_BIT];

    els_reg_steer u_reg_steer (
        .munged   (reg_munged),
        .addr     (preq.addr),
        .size     (preq.size),
        .lane_en  (lane_en),
        .reg_byte (reg_byte),
        .bad      (steer_bad)
    );

    // classify the processor request
    wire [3:0] first_word  = {preq.dword, reg_byte[preq.addr][2]};
    wire       reg_req     = proc_req & ~preq.to_pci;
    wire       reg_bad     = steer_bad | (first_word > WORD_LAST);
    wire       reg_ok      = reg_req & ~reg_bad;
    wire       pci_reg_hit = reg_ok & (first_word >= WORD_PCI0);
    wire       img_req     = proc_req & preq.to_pci;
    wire       pci_fire    = img_req | pci_reg_hit;
    wire       proc_reg_wr = reg_ok & preq.we & ~pci_reg_hit;

    // pci mapping from image field or from register mode bit
    assign pci_mode = img_req
        ? els_end_type'(cfg[CFG_IMG][2*preq.img +: 2])
        : (reg_munged ? END_MUNGED : END_BIG);
    assign pci_src = img_req ? SRC_IMAGE
        : els_src_type'(2'(first_word - WORD_PCI0) + 2'h1);

    els_pci_steer u_pci_steer (
        .mode         (pci_mode),
        .proc_data    (preq.data),
        .lane_en      (lane_en),
        .addr         (preq.addr),
        .size         (preq.size),
        .pci_data     (pci_data),
        .pci_be       (pci_be),
        .pci_addr_low (pci_addr_low)
    );

    // readable words seen from the processor port
    assign rd_words[0] = cfg[CFG_CTRL];
    assign rd_words[1] = cfg[CFG_IMG];
    assign rd_words[2] = cfg[CFG_DMA];
    assign rd_words[3] = cfg[CFG_MASK];
    assign rd_words[4] = 32'(status);
    assign rd_words[5] = 32'(dma_cur);
    assign rd_words[6] = 32'h0;
    assign rd_words[7] = 32'h0;

    // read lanes gather little-endian register bytes
    for (genvar n = 0; n < LANES; n++) begin : g_rd
        wire [3:0] w = {preq.dword, reg_byte[n][2]};
        assign next_rdata[8*(LANES-1-n) +: 8] =
            (lane_en[n] && (w < WORD_PCI0))
            ? rd_words[w[2:0]][8*reg_byte[n][1:0] +: 8] : 8'h0;
    end

    // configuration writes: apb word, then processor lanes
    always_comb begin
        next_cfg = cfg;
        if (apb_write && hit_cfg) begin
            next_cfg[paddr[3:2]] = pwdata;
        end
        for (int n = 0; n < LANES; n++) begin
            if (proc_reg_wr && lane_en[n]
                && ({preq.dword, reg_byte[n][2]} < 4'(CFG_WORDS))) begin
                next_cfg[2'({preq.dword, reg_byte[n][2]})]
                        [8*reg_byte[n][1:0] +: 8] =
                    preq.data[8*(LANES-1-n) +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < CFG_WORDS; k++) begin
                cfg[k] <= CFG_RESET;
            end
        end else begin
            cfg <= next_cfg;
        end
    end

    // dma channels latch a mode per transfer or list element
    for (genvar c = 0; c < NUM_DMA; c++) begin : g_dma
        assign next_dma[2*c +: 2] = !dma_load[c] ? dma_cur[2*c +: 2] :
            dma_from_list[c] ? dma_elem_end[2*c +: 2]
                             : cfg[CFG_DMA][2*c +: 2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_cur <= '0;
        end else begin
            dma_cur <= next_dma;
        end
    end

    // sticky events, set wins over write-one-to-clear
    assign irq_event   = {|dma_load, pci_fire, reg_req & reg_bad};
    assign w1c         = (apb_write && hit_status) ? pwdata[IRQ_W-1:0]
                                                   : '0;
    assign next_status = (status & ~w1c) | irq_event;
    assign irq         = |(status & cfg[CFG_MASK][IRQ_W-1:0]);
    assign img_end     = cfg[CFG_IMG][2*NUM_IMG-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            prdata <= 32'h0;
        end else begin
            status <= next_status;
            prdata <= apb_setup ? apb_rd_word : prdata;
        end
    end

    // processor answers one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proc_ack                <= 1'b0;
            proc_transfer_error_ack <= 1'b0;
            proc_rdata              <= 64'h0;
        end else begin
            proc_ack                <= reg_ok | img_req;
            proc_transfer_error_ack <= reg_req & reg_bad;
            proc_rdata <= reg_ok ? next_rdata : proc_rdata;
        end
    end

    // generated pci transfer and pass-through forwarding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_req       <= 1'b0;
            pci_out       <= '0;
            pci_fwd_valid <= 1'b0;
            pci_fwd_out   <= 64'h0;
        end else begin
            pci_req       <= pci_fire;
            pci_out       <= pci_fire ? {pci_src, pci_addr_low, pci_be,
                                         pci_data} : pci_out;
            pci_fwd_valid <= pci_fwd_valid_in;
            pci_fwd_out   <= pci_fwd_in;
        end
    end

    // checks
    AST_FWD: assert property (@(posedge pclk) disable iff (!presetn)
        pci_fwd_valid_in |=> pci_fwd_valid
            && (pci_fwd_out == $past(pci_fwd_in)))
        else $error("forwarded pci data altered");

    AST_BE_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
        (reg_req && preq.we && !reg_munged && preq.size == SIZE_BYTE
            && preq.dword == 3'h0 && preq.addr == 3'h0 && !apb_write)
        |=> cfg[CFG_CTRL][31:24] == $past(preq.data[63:56]))
        else $error("big-endian byte lane 0 not at register byte 3");

    AST_ML_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
        (reg_req && preq.we && reg_munged && preq.size == SIZE_BYTE
            && preq.dword == 3'h0 && preq.addr == 3'h0 && !apb_write)
        |=> cfg[CFG_IMG][7:0] == $past(preq.data[63:56]))
        else $error("munged byte not at register byte 4");

    AST_UNALIGNED: assert property (@(posedge pclk) disable iff (!presetn)
        (reg_req && reg_munged && preq.size == SIZE_HALF && preq.addr[0])
        |=> proc_transfer_error_ack && !proc_ack ##1
            !proc_transfer_error_ack || $past(proc_req))
        else $error("unaligned munged access not refused");

    AST_CONF: assert property (@(posedge pclk) disable iff (!presetn)
        (reg_req && !reg_munged && preq.dword == 3'h3
            && preq.addr == 3'h0 && preq.size == SIZE_WORD)
        |=> pci_req && pci_out.src == SRC_CONF && pci_out.be == 8'h0f)
        else $error("config data access did not reach pci");

    AST_BE_PCI: assert property (@(posedge pclk) disable iff (!presetn)
        (img_req && pci_mode == END_BIG && preq.addr == 3'h0
            && preq.size == SIZE_BYTE)
        |=> pci_out.be == 8'h01
            && pci_out.data[7:0] == $past(preq.data[63:56]))
        else $error("big-endian lane 0 not on pci lane 0");

    AST_TLE: assert property (@(posedge pclk) disable iff (!presetn)
        (img_req && pci_mode == END_TRUE_LITTLE && preq.addr == 3'h0
            && preq.size == SIZE_BYTE) |=> pci_out.be == 8'h08)
        else $error("true little lane 0 not on pci lane 3");

    AST_DMA: assert property (@(posedge pclk) disable iff (!presetn)
        (dma_load[0] && dma_from_list[0])
        |=> dma_cur[1:0] == $past(dma_elem_end[1:0]))
        else $error("dma list element mode not taken");

    AST_IMG: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_write && paddr == OFS_IMG_END && !proc_req)
        |=> img_end == $past(pwdata[2*NUM_IMG-1:0]))
        else $error("image endian fields not updated");
endmodule : els_endian_lane_steering

// [els_proc_model.sv]
`timescale 1ns/1ps
module els_proc_model
    import els_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             go,
    input  wire logic             munged,
    input  wire els_proc_req_type req,
    output els_proc_req_type      proc_req_data,
    output logic                  proc_req
);
    logic [2:0] flip;

    // xor applied to the low address bits by a munging processor
    assign flip = (!munged || req.to_pci) ? 3'h0 :
                  (req.size == 4'h4) ? 3'h4 :
                  (req.size == 4'h2) ? 3'h6 : 3'h7;

    // one-cycle request; idle payload toggles so stale data is not seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proc_req      <= 1'b0;
            proc_req_data <= '0;
        end else begin
            proc_req <= go;
            if (go) begin
                // unmunged request from the bench, address munged here
                proc_req_data <= {req.we, req.to_pci, req.img, req.dword,
                                  req.addr ^ flip, req.size, req.data};
            end else begin
                proc_req_data <= ~proc_req_data;
            end
        end
    end
endmodule : els_proc_model

// [els_endian_lane_steering_tb.sv]
`timescale 1ns/1ps
module els_endian_lane_steering_tb;
    import els_pkg::*;
    logic             pclk, presetn, psel, penable, pwrite, go, munged;
    logic             pready, pslverr, irq, proc_req, proc_ack, terr;
    logic             pci_req, fvi, fvo, er;
    logic [7:0]       paddr, dma_ee;
    logic [31:0]      pwdata, prdata, lf, rd;
    logic [31:0]      sh [0:3];
    logic [63:0]      proc_rdata, fin, fout, d;
    logic [3:0]       dma_ld, dma_fl;
    logic [7:0]       dma_cur;
    logic [15:0]      img_end;
    els_proc_req_type rq, prd;
    els_pci_req_type  po;
    int               fail_count, n_tests;

    els_endian_lane_steering #(.NUM_IMG(8), .NUM_DMA(4)) u_els_endian_lane_steering (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .proc_req(proc_req), .proc_req_data(prd), .proc_ack(proc_ack),
        .proc_transfer_error_ack(terr), .proc_rdata(proc_rdata),
        .pci_req(pci_req), .pci_out(po), .pci_fwd_valid_in(fvi),
        .pci_fwd_in(fin), .pci_fwd_valid(fvo), .pci_fwd_out(fout),
        .dma_load(dma_ld), .dma_from_list(dma_fl), .dma_elem_end(dma_ee),
        .dma_cur(dma_cur), .img_end(img_end));

    els_proc_model u_els_proc_model (
        .pclk(pclk), .presetn(presetn), .go(go), .munged(munged),
        .req(rq), .proc_req_data(prd), .proc_req(proc_req));

    // clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd

    // munge value for the current register mode
    function automatic logic [2:0] fl(input logic [3:0] sz);
        return !munged ? 3'h0 : sz == 4'h4 ? 3'h4 :
               sz == 4'h2 ? 3'h6 : 3'h7;
    endfunction : fl

    // expected register image after a processor write
    function automatic void shw(input logic [2:0] ab, input logic [3:0] sz,
                                input logic [63:0] dt);
        logic [2:0] k;
        logic [2:0] m;
        for (int i = 0; i < sz; i++) begin
            k = ab + 3'(i);
            m = k ^ fl(sz);
            sh[2 + m[2]][8*(3 - m[1:0]) +: 8] = dt[63 - 8*k -: 8];
        end
    endfunction : shw

    // expected pci lanes for a full double transfer
    function automatic logic [63:0] pmap(input logic [1:0] md,
                                         input logic [63:0] dt);
        logic [2:0] s;
        for (int p = 0; p < 8; p++) begin
            s = md == 2'h0 ? 3'(p) : md == 2'h3 ? {p[2], ~p[1], ~p[0]}
                                                : 3'(7 - p);
            pmap[8*p +: 8] = dt[63 - 8*s -: 8];
        end
    endfunction : pmap

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic proc(input logic w, input logic tp, input logic [2:0] im,
                        input logic [2:0] dw, input logic [2:0] a,
                        input logic [3:0] sz, input logic [63:0] dt);
        @(posedge pclk);
        go <= 1'b1;
        rq <= '{w, tp, im, dw, a, sz, dt};
        @(posedge pclk);
        go <= 1'b0;
        do @(negedge pclk); while ((proc_ack | terr) !== 1'b1);
    endtask : proc

    task automatic irq_is(input logic e);
        @(negedge pclk);
        chk(irq, e);
    endtask : irq_is

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        logic [31:0] r;
        logic [3:0]  sz;
        logic [2:0]  ab;
        {presetn, psel, penable, pwrite, go, munged, fvi} = '0;
        {paddr, pwdata, fin, dma_ld, dma_fl, dma_ee} = '0;
        rq = '0;
        lf = 32'd75337;
        fail_count = 0;
        n_tests = 0;
        for (int i = 0; i < 4; i++) sh[i] = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4*i), 32'h0);
            chk(rd, 32'h0);
        end
        chk({img_end, dma_cur}, 24'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        $display("reset and map test done");
        apb(1'b1, OFS_IMG_END, 32'he4);
        chk(img_end, 16'h00e4);
        for (int md = 0; md < 4; md++) begin
            d = {rnd(), rnd()};
            proc(1'b1, 1'b1, 3'(md), 3'h0, 3'h0, 4'h8, d);
            chk(po.data, pmap(2'(md), d));
            chk({pci_req, proc_ack, po.be}, 10'h3ff);
        end
        for (int a = 0; a < 8; a++) begin
            d = {rnd(), rnd()};
            proc(1'b1, 1'b1, 3'h0, 3'h0, 3'(a), 4'h1, d);
            chk(po.be, 8'h1 << a);
            chk(po.data[8*a +: 8], d[63 - 8*a -: 8]);
        end
        // true little image, munged image and config data register corner cases
        d = {rnd(), rnd()};
        proc(1'b1, 1'b1, 3'h3, 3'h0, 3'h0, 4'h1, d);
        chk({po.be, po.data[31:24]}, {8'h08, d[63:56]});
        proc(1'b1, 1'b1, 3'h1, 3'h0, 3'h0, 4'h1, d);
        chk({po.addr_low, po.be}, {3'h7, 8'h80});
        proc(1'b1, 1'b0, 3'h0, 3'h3, 3'h0, 4'h4, d);
        chk({po.src, po.be}, {SRC_CONF, 8'h0f});
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            fvi <= 1'b1;
            fin <= {rnd(), rnd()};
            @(posedge pclk);
            fvi <= 1'b0;
            d = fin;
            fin <= ~fin;
            @(negedge pclk);
            chk(fout, d);
            chk(fvo, 1'b1);
        end
        $display("pci path test done");
        for (int mo = 0; mo < 2; mo++) begin
            apb(1'b1, OFS_CTRL, 32'(mo));
            munged = mo[0];
            repeat (12) begin
                r = rnd();
                if (munged) begin
                    sz = r[1] ? 4'h4 : r[0] ? 4'h2 : 4'h1;
                    ab = r[4:2] & ~3'(sz - 4'h1);
                end else begin
                    sz = {2'b0, r[1:0]} + 4'h1;
                    ab[2] = r[2];
                    ab[1:0] = (r[4:3] + sz > 4) ? 2'(4 - sz) : r[4:3];
                end
                d = {rnd(), rnd()};
                proc(1'b1, 1'b0, 3'h0, 3'h1, ab ^ fl(sz), sz, d);
                chk({proc_ack, terr}, 2'b10);
                shw(ab, sz, d);
                apb(1'b0, OFS_DMA_END, 32'h0);
                chk(rd, sh[2]);
                apb(1'b0, OFS_MASK, 32'h0);
                chk(rd, sh[3]);
            end
            proc(1'b0, 1'b0, 3'h0, 3'h1, 3'h4 ^ fl(4'h4), 4'h4, d);
            chk(proc_rdata[31:0], sh[3 - mo]);
            // byte on bus lane 0 of word pair 0
            proc(1'b1, 1'b0, 3'h0, 3'h0, fl(4'h1), 4'h1, d);
            apb(1'b0, 8'(4*mo), 32'h0);
            chk(rd, mo ? {24'h0, d[63:56]} : {d[63:56], 24'h0});
            $display("register mode %0d test done", mo);
        end
        for (int ch = 0; ch < 5; ch++) begin
            r = rnd();
            if (ch == 4) r[0] = 1'b1; // last pass: channel 0 from list
            @(posedge pclk);
            dma_ld <= 4'h1 << ch[1:0];
            dma_fl <= r[3:0];
            dma_ee <= r[15:8];
            @(posedge pclk);
            dma_ld <= 4'h0;
            @(posedge pclk);
            @(negedge pclk);
            chk(dma_cur[2*ch[1:0] +: 2], r[ch[1:0]] ? r[8 + 2*ch[1:0] +: 2]
                : sh[2][2*ch[1:0] +: 2]);
        end
        $display("dma mode test done");
        apb(1'b1, OFS_MASK, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h7);
        irq_is(1'b0);
        proc(1'b1, 1'b0, 3'h0, 3'h1, 3'h1 ^ fl(4'h2), 4'h2, d);
        chk({proc_ack, terr}, 2'b01);
        proc(1'b1, 1'b0, 3'h0, 3'h1, 3'h0, 4'h3, d);
        chk({proc_ack, terr}, 2'b01);
        apb(1'b0, OFS_DMA_END, 32'h0);
        chk(rd, sh[2]);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h1);
        irq_is(1'b1);
        apb(1'b1, OFS_MASK, 32'h0);
        irq_is(1'b0);
        apb(1'b1, OFS_MASK, 32'h1);
        irq_is(1'b1);
        apb(1'b1, OFS_STATUS, 32'h1);
        irq_is(1'b0);
        $display("refusal and interrupt test done");
        end_of_test();
    end
endmodule : els_endian_lane_steering_tb
